// *** sadc_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none

// converter clock enable: one pulse every 1, 2, 4 or 8 clocks
module sadc_clk_div (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [1:0] div_sel_i,
  // enable pulse
  output logic ce_o
);

  typedef struct packed {
    logic [2:0] cnt;
    logic ce;
  } sadc_div_s;

  sadc_div_s st;
  sadc_div_s next_st;
  logic [2:0] last;

  // divider restarts while idle so each conversion starts aligned
  always_comb begin
    next_st = st;
    last = 3'((4'h1 << div_sel_i) - 4'h1);
    next_st.ce = 1'b0;
    if (!run_i) begin
      next_st.cnt = 3'h0;
    end else if (st.cnt >= last) begin
      next_st.cnt = 3'h0;
      next_st.ce = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ce_o = st.ce;

endmodule

`default_nettype wire

// *** sadc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] any control write aborts and restarts, unless channel off
// [R2] done flag sets on finish; write or low read clears
// [R3] interrupt at each end when enabled; reset clears enable
// [R4] continuous bit repeats conversions, updating results each time
// [R5] continuous ends on reset, stop, clock write, control write
// [R6] after stop abort only a control write restarts
// [R7] continuous write aborts current and starts continuous run
// [R8] software keeps bus clock fast enough for exact timing
// [R9] single mode: one conversion per write; reset clears
// [R10] channel select is a five-bit field
// [R11] channel all ones powers off, isolates, no extra conversion
// [R12] converter powers down automatically after each conversion; continuous runs stay powered
// [R13] codes: 0-12 external, bandgap, high, low, off
// [R14] software avoids unused or reserved channel codes
// [R15] break-clear set: clears in break stick afterwards
// [R16] break-clear clear: accesses in break keep status bits
// [R17] two-step clear: first step before break, hold, finish after
// [R18] software powers voltage monitor before bandgap conversion
// [R19] no hardware trigger; only register writes start conversions
// [R20] done flag sets regardless of interrupt enable
// [R21] high result read blocks updates until low read
// [R22] async clock enable keeps conversions running in stop
// [R23] interrupt output is done flag and enable
module sadc_ctrl
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // system integration unit
  input wire logic break_i,
  input wire logic break_clear_enable_i,
  input wire logic stop_i,
  // analog comparator, asynchronous to clk_i
  input wire logic comparator_i,
  // analog front end and interrupt
  output sadc_afe_s afe_o,
  output logic irq_o
);

  typedef struct packed {
    sadc_phase_e phase;
    logic [4:0] cnt;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic [9:0] result;
    logic done;
    logic irq_en;
    logic cont;
    logic [4:0] chan;
    logic running;
    logic lock;
    logic [7:0] clkcfg;
    logic stop_q;
    logic cmp_meta;
    logic cmp_sync;
    logic ack;
    logic [31:0] dat;
    logic irq;
    sadc_afe_s afe;
  } sadc_state_s;

  sadc_state_s st;
  sadc_state_s next_st;
  logic ce;
  logic req;
  logic wr_sc;
  logic wr_ck;
  logic rd_hi;
  logic rd_lo;
  logic may_clear;
  logic stop_abort;
  logic [7:0] rd_byte;
  logic ten_bit;
  logic finish;

  // converter clock enable from the selected divide ratio
  sadc_clk_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st.phase != SADC_IDLE),
    .div_sel_i(st.clkcfg[SADC_CK_DIV_LSB +: 2]),
    .ce_o(ce)
  );

  // bus decode; a request is acted on in the cycle before ack
  always_comb begin
    req = cyc_i && stb_i && !st.ack;
    wr_sc = req && we_i && sel_i[0] && (adr_i == SADC_OFS_STATUS_CONTROL);
    wr_ck = req && we_i && sel_i[0] && (adr_i == SADC_OFS_CLOCK_CONFIG);
    rd_hi = req && !we_i && (adr_i == SADC_OFS_RESULT_HIGH);
    rd_lo = req && !we_i && (adr_i == SADC_OFS_RESULT_LOW);
    ten_bit = st.clkcfg[SADC_CK_MODE_LSB +: 2] != SADC_MODE_8BIT;
    // status bits are frozen in break unless break-clear is set
    may_clear = !break_i || break_clear_enable_i; // [R15] [R16]
    // stop with the async clock off kills the conversion
    stop_abort = stop_i && !st.stop_q && !st.clkcfg[SADC_CK_ASYNC_BIT]; // [R22]
    finish = (st.phase == SADC_CONVERT) && ce && (st.cnt == 5'h0)
      && (st.bit_idx == 4'h0);
  end

  // read data mux; unmapped addresses read as zero
  always_comb begin
    rd_byte = 8'h00;
    case (adr_i)
      SADC_OFS_STATUS_CONTROL: begin
        rd_byte = {st.done, st.irq_en, st.cont, st.chan};
      end
      SADC_OFS_RESULT_HIGH: begin
        rd_byte = ten_bit ? {6'h00, st.result[9:8]} : 8'h00;
      end
      SADC_OFS_RESULT_LOW: begin
        rd_byte = ten_bit ? st.result[7:0] : st.result[9:2];
      end
      SADC_OFS_CLOCK_CONFIG: begin
        rd_byte = st.clkcfg;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // all next-state logic of the block
  always_comb begin
    next_st = st;
    // comparator passes two flops before use
    next_st.cmp_meta = comparator_i;
    next_st.cmp_sync = st.cmp_meta;
    next_st.stop_q = stop_i;
    next_st.ack = req;
    next_st.dat = req ? {24'h000000, rd_byte} : 32'h00000000;

    // sar sequencer, stepped by the converter clock enable
    case (st.phase)
      SADC_IDLE: begin
        next_st.cnt = 5'h0;
      end
      SADC_SAMPLE: begin
        if (ce) begin
          if (st.cnt == 5'h0) begin
            next_st.phase = SADC_CONVERT;
            next_st.bit_idx = SADC_TOP_BIT;
            next_st.sar = 10'h200;
            next_st.cnt = SADC_SETTLE_CYC;
          end else begin
            next_st.cnt = st.cnt - 5'h1;
          end
        end
      end
      SADC_CONVERT: begin
        // wait for the comparator to settle through its synchroniser
        if (st.cnt != 5'h0) begin
          next_st.cnt = st.cnt - 5'h1;
        end else if (ce) begin
          if (!st.cmp_sync) begin
            next_st.sar[st.bit_idx] = 1'b0;
          end
          if (st.bit_idx != 4'h0) begin
            next_st.bit_idx = st.bit_idx - 4'h1;
            next_st.sar[st.bit_idx - 4'h1] = 1'b1;
            next_st.cnt = SADC_SETTLE_CYC;
          end
        end
      end
      default: begin
        next_st.phase = SADC_IDLE;
      end
    endcase

    // end of a conversion
    if (finish) begin
      next_st.done = 1'b1; // [R2] [R20]
      // high read holds later results until the low read
      if (!(st.lock && ten_bit)) begin // [R21]
        next_st.result = next_st.sar; // [R4]
      end
      if (st.running && st.cont) begin
        next_st.phase = SADC_SAMPLE; // [R4]
        next_st.cnt = st.clkcfg[SADC_CK_LSMP_BIT] ? SADC_SAMPLE_LONG_CYC - 5'h1
                                                  : SADC_SAMPLE_SHORT_CYC - 5'h1;
      end else begin
        next_st.phase = SADC_IDLE; // [R9] [R12]
        next_st.running = 1'b0;
      end
    end

    // result reads: high read arms the lock, low read clears it and done
    if (rd_hi && ten_bit) begin
      next_st.lock = 1'b1; // [R21]
    end
    if (rd_lo) begin
      next_st.lock = 1'b0;
      // the second step taken after a break completes the clear
      if (may_clear && !finish) begin
        next_st.done = 1'b0; // [R2] [R3] [R17]
      end
    end

    // clock config write ends a continuous run
    if (wr_ck) begin
      next_st.clkcfg = dat_i[7:0];
      next_st.phase = SADC_IDLE; // [R5]
      next_st.running = 1'b0;
    end

    // stop with async clock off aborts; nothing restarts by itself
    if (stop_abort) begin
      next_st.phase = SADC_IDLE; // [R5] [R6]
      next_st.running = 1'b0;
    end

    // control write: abort and start unless the channel is off
    if (wr_sc) begin
      next_st.irq_en = dat_i[SADC_SC_IEN_BIT];
      next_st.cont = dat_i[SADC_SC_CONT_BIT];
      next_st.chan = dat_i[SADC_SC_CHAN_LSB +: SADC_CHAN_W]; // [R10]
      if (may_clear) begin
        next_st.done = 1'b0; // [R2] [R16]
      end
      if (dat_i[SADC_SC_CHAN_LSB +: SADC_CHAN_W] != SADC_CHAN_OFF) begin
        // only a register write starts a conversion
        next_st.phase = SADC_SAMPLE; // [R1] [R7] [R19]
        next_st.running = 1'b1; // [R9]
        next_st.cnt = st.clkcfg[SADC_CK_LSMP_BIT] ? SADC_SAMPLE_LONG_CYC - 5'h1
                                                  : SADC_SAMPLE_SHORT_CYC - 5'h1;
      end else begin
        next_st.phase = SADC_IDLE; // [R11]
        next_st.running = 1'b0;
      end
    end

    // interrupt follows flag and enable so it drops with the flag
    next_st.irq = next_st.done && next_st.irq_en; // [R3] [R23]

    // front end: powered only while converting, pad isolated when off
    next_st.afe.power_down = next_st.phase == SADC_IDLE; // [R12]
    next_st.afe.isolate = next_st.chan == SADC_CHAN_OFF; // [R11]
    next_st.afe.sample = next_st.phase == SADC_SAMPLE;
    next_st.afe.channel = next_st.chan; // [R13]
    next_st.afe.trial_code = next_st.sar;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.chan <= SADC_CHAN_RST;
      st.clkcfg <= SADC_CLKCFG_RST;
      st.afe.power_down <= 1'b1;
      st.afe.isolate <= 1'b1;
      st.afe.channel <= SADC_CHAN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = st.dat;
  assign ack_o = st.ack;
  assign afe_o = st.afe;
  assign irq_o = st.irq;

endmodule

`default_nettype wire

// *** sadc_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sadc_chk
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // system, analog, interrupt
  input wire logic break_i,
  input wire logic break_clear_enable_i,
  input wire logic stop_i,
  input wire logic comparator_i,
  input wire sadc_afe_s afe_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // taken requests; a protected break keeps the flag, so clears need clr
  wire rq = cyc_i & stb_i & ~ack_o & sel_i[0];
  wire clr = ~break_i | break_clear_enable_i;
  wire wsc = rq & we_i & (adr_i == SADC_OFS_STATUS_CONTROL);
  wire wck = rq & we_i & (adr_i == SADC_OFS_CLOCK_CONFIG);
  wire rlo = rq & ~we_i & (adr_i == SADC_OFS_RESULT_LOW);
  wire off = dat_i[4:0] == SADC_CHAN_OFF;
  chk_write_clears_irq: assert property (wsc && clr |=> !irq_o)
    else $error("irq kept after write");
  chk_read_clears_irq: assert property (rlo && clr && afe_o.power_down |=> !irq_o)
    else $error("irq kept after read");
  chk_write_starts: assert property (wsc && !off |=> afe_o.sample && !afe_o.power_down
    && afe_o.channel == $past(dat_i[4:0])) else $error("write did not start");
  chk_off_stops: assert property (wsc && off |=> afe_o.power_down [*2])
    else $error("off code converted");
  chk_off_isolates: assert property (afe_o.isolate == (afe_o.channel == SADC_CHAN_OFF))
    else $error("isolate wrong");
  chk_off_idle: assert property (afe_o.isolate |-> afe_o.power_down && !afe_o.sample)
    else $error("isolated but active");
  chk_clock_write_idles: assert property (wck |=> afe_o.power_down && !afe_o.sample)
    else $error("clock write kept running");
  chk_irq_at_end: assert property ($rose(irq_o) && !break_i |-> !$past(afe_o.power_down))
    else $error("irq without conversion");
  // main scenarios reached
  cov_cont: cover property (wsc && dat_i[SADC_SC_CONT_BIT] && !off);
  cov_irq: cover property ($rose(irq_o));
  cov_break_read: cover property (rlo && !clr);
endmodule
bind sadc_ctrl sadc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .break_i(break_i), .break_clear_enable_i(break_clear_enable_i), .stop_i(stop_i),
  .comparator_i(comparator_i), .afe_o(afe_o), .irq_o(irq_o));
`default_nettype wire

// *** sadc_pkg.sv ***
package sadc_pkg;

  // register word offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] SADC_OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] SADC_OFS_RESULT_HIGH = 8'h04;
  localparam logic [7:0] SADC_OFS_RESULT_LOW = 8'h08;
  localparam logic [7:0] SADC_OFS_CLOCK_CONFIG = 8'h0C;

  // status_control_reg fields
  localparam int SADC_SC_DONE_BIT = 7;
  localparam int SADC_SC_IEN_BIT = 6;
  localparam int SADC_SC_CONT_BIT = 5;
  localparam int SADC_SC_CHAN_LSB = 0;
  localparam int SADC_CHAN_W = 5;

  // clock_config_reg fields
  localparam int SADC_CK_ASYNC_BIT = 7;
  localparam int SADC_CK_LSMP_BIT = 4;
  localparam int SADC_CK_DIV_LSB = 5;
  localparam int SADC_CK_MODE_LSB = 2;
  localparam int SADC_CK_LPC_BIT = 0;
  localparam int SADC_CK_ICLK_BIT = 1;

  // channel codes
  localparam logic [4:0] SADC_CHAN_OFF = 5'h1F;
  localparam logic [4:0] SADC_CHAN_LAST_EXT = 5'h0C;
  localparam logic [4:0] SADC_CHAN_BANDGAP = 5'h1A;
  localparam logic [4:0] SADC_CHAN_REFH = 5'h1D;
  localparam logic [4:0] SADC_CHAN_REFL = 5'h1E;

  // conversion mode codes
  localparam logic [1:0] SADC_MODE_8BIT = 2'h0;
  localparam logic [1:0] SADC_MODE_10BIT = 2'h1;

  // reset values
  localparam logic [4:0] SADC_CHAN_RST = 5'h1F;
  localparam logic [7:0] SADC_CLKCFG_RST = 8'h00;

  // timing: sample time in converter clocks, rounded up to whole clocks
  localparam int SADC_SAMPLE_SHORT_X10 = 35;
  localparam int SADC_SAMPLE_LONG_X10 = 235;
  localparam logic [4:0] SADC_SAMPLE_SHORT_CYC = 5'((SADC_SAMPLE_SHORT_X10 + 9) / 10);
  localparam logic [4:0] SADC_SAMPLE_LONG_CYC = 5'((SADC_SAMPLE_LONG_X10 + 9) / 10);
  // comparator settle time after a trial code change
  localparam int SADC_SETTLE_NS = 15;
  localparam int SADC_CLK_MHZ = 200;
  localparam logic [4:0] SADC_SETTLE_CYC =
    5'((SADC_SETTLE_NS * SADC_CLK_MHZ + 999) / 1000);
  localparam logic [3:0] SADC_TOP_BIT = 4'h9;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_CONVERT
  } sadc_phase_e;

  // analog front-end controls
  typedef struct packed {
    logic power_down;
    logic isolate;
    logic sample;
    logic [4:0] channel;
    logic [9:0] trial_code;
  } sadc_afe_s;

endpackage

// *** tb_sadc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sadc_ctrl
  import sadc_pkg::*;
;
  // comparator held high so every trial bit is kept
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic break_i = 1'b0, break_clear_enable_i = 1'b0, stop_i = 1'b0, comparator_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, irq_o;
  sadc_afe_s afe_o;
  logic [7:0] rd;
  int fails = 0, checks = 0;
  localparam logic [7:0] SC = SADC_OFS_STATUS_CONTROL;
  localparam logic [7:0] HI = SADC_OFS_RESULT_HIGH;
  localparam logic [7:0] LO = SADC_OFS_RESULT_LOW;
  localparam logic [7:0] CK = SADC_OFS_CLOCK_CONFIG;
  // only defined codes are used; bandgap assumes the voltage monitor is powered
  logic [4:0] ch [5] = '{5'h00, SADC_CHAN_LAST_EXT, SADC_CHAN_BANDGAP, SADC_CHAN_REFH,
    SADC_CHAN_REFL};
  // device under test
  sadc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .break_i(break_i), .break_clear_enable_i(break_clear_enable_i), .stop_i(stop_i),
    .comparator_i(comparator_i), .afe_o(afe_o), .irq_o(irq_o));
  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one classic cycle; ack and read data are taken at the rising edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      cmp(8'h00, 8'h01);
      end_sim;
    end
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    cmp(rd, e);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (irq_o !== 1'b1 && n < 400);
    cmp({7'h0, irq_o}, 8'h01);
    if (irq_o !== 1'b1) end_sim;
  endtask
  // scenario sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(SC, 8'h1F);
    rdc(8'h10, 8'h00);
    $display("test reset done");
    wb(1'b1, CK, 8'h04);
    wb(1'b1, SC, 8'h43);
    @(negedge clk_i);
    cmp({3'h0, afe_o.channel}, 8'h03);
    wait_irq;
    cmp({7'h0, afe_o.power_down}, 8'h01);
    rdc(SC, 8'hC3);
    rdc(HI, 8'h03);
    rdc(LO, 8'hFF);
    @(negedge clk_i);
    cmp({7'h0, irq_o}, 8'h00);
    wb(1'b1, SC, 8'h05);
    rd = 8'h00;
    for (int i = 0; i < 40 && !rd[7]; i++) begin
      wb(1'b0, SC, 8'h00);
    end
    cmp(rd, 8'h85);
    if (!rd[7]) end_sim;
    @(negedge clk_i);
    cmp({7'h0, irq_o}, 8'h00);
    wb(1'b1, SC, 8'h1F);
    repeat (100) @(negedge clk_i);
    rdc(SC, 8'h1F);
    $display("test single done");
    wb(1'b1, SC, 8'h62);
    wait_irq;
    rdc(LO, 8'hFF);
    wait_irq;
    wb(1'b1, CK, 8'h04);
    rdc(LO, 8'hFF);
    repeat (100) @(negedge clk_i);
    cmp({7'h0, irq_o}, 8'h00);
    wb(1'b1, SC, 8'h62);
    @(posedge clk_i);
    stop_i <= 1'b1;
    @(posedge clk_i);
    stop_i <= 1'b0;
    repeat (100) @(negedge clk_i);
    cmp({6'h0, afe_o.power_down, irq_o}, 8'h02);
    wb(1'b1, SC, 8'h42);
    wait_irq;
    $display("test continuous done");
    @(posedge clk_i);
    break_i <= 1'b1;
    rdc(LO, 8'hFF);
    @(negedge clk_i);
    cmp({7'h0, irq_o}, 8'h01);
    @(posedge clk_i);
    break_clear_enable_i <= 1'b1;
    rdc(LO, 8'hFF);
    @(posedge clk_i);
    break_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    cmp({7'h0, irq_o}, 8'h00);
    $display("test break done");
    // 8-bit, long sample, divide by two, async clock kept through stop
    wb(1'b1, CK, 8'hB0);
    rdc(CK, 8'hB0);
    wb(1'b1, SC, 8'h41);
    @(posedge clk_i);
    stop_i <= 1'b1;
    @(posedge clk_i);
    stop_i <= 1'b0;
    wait_irq;
    rdc(HI, 8'h00);
    rdc(LO, 8'hFF);
    $display("test async eight bit done");
    foreach (ch[i]) begin
      wb(1'b1, SC, {3'h0, ch[i]});
      @(negedge clk_i);
      cmp({2'h0, afe_o.isolate, afe_o.channel}, {3'h0, ch[i]});
    end
    $display("test channels done");
    end_sim;
  end
endmodule
`default_nettype wire
